// ### hdl/sef_pkg.sv
// ----------------------------------------------------------------
// Register map and field layout of the event status flags
// ----------------------------------------------------------------
package sef_pkg;

  // Data width of every status register
  localparam int SEF_DATA_W = 8;

  // ----------------------------------------------------------------
  // Register addresses on the serial register port
  // ----------------------------------------------------------------
  localparam logic [7:0] SEF_ADDR_PRIMARY   = 8'hb7;  // Primary event status, write one to clear
  localparam logic [7:0] SEF_ADDR_SECONDARY = 8'hb8;  // Valid and proximity saturation detail
  localparam logic [7:0] SEF_ADDR_SYSDETAIL = 8'hbb;  // System event detail

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SEF_RST_PRIMARY   = 8'h00;
  localparam logic [7:0] SEF_RST_SECONDARY = 8'h00;
  localparam logic [7:0] SEF_RST_SYSDETAIL = 8'h00;
  localparam logic [7:0] SEF_RST_RDATA     = 8'h00;

  // ----------------------------------------------------------------
  // Primary status bit positions
  // ----------------------------------------------------------------
  localparam int SEF_BIT_AMB_SAT   = 7;  // Ambient saturation
  localparam int SEF_BIT_FLK_SAT   = 6;  // Flicker saturation
  localparam int SEF_BIT_PROX_SAT  = 5;  // Proximity saturation
  localparam int SEF_BIT_PROX_EVT  = 4;  // Proximity threshold event
  localparam int SEF_BIT_AMB_EVT   = 3;  // Ambient threshold event
  localparam int SEF_BIT_BUF_EVT   = 2;  // Buffer level event
  localparam int SEF_BIT_CAL_EVT   = 1;  // Calibration event
  localparam int SEF_BIT_SYS_EVT   = 0;  // System event summary

  // ----------------------------------------------------------------
  // Secondary status bit positions
  // ----------------------------------------------------------------
  localparam int SEF_BIT_PROX_VALID = 7;  // Proximity result valid
  localparam int SEF_BIT_AMB_VALID  = 6;  // Ambient result valid
  localparam int SEF_SAT_DETAIL_W   = 6;  // Per-channel saturation detail, bits 5..0

  // ----------------------------------------------------------------
  // System detail bit positions
  // ----------------------------------------------------------------
  localparam int SEF_BIT_FLK_CHANGE = 3;  // Flicker result changed
  localparam int SEF_BIT_SYNC_ERR   = 0;  // Synchronisation error

  // ----------------------------------------------------------------
  // Calibration cause positions
  // ----------------------------------------------------------------
  localparam int SEF_CAUSE_W        = 4;
  localparam int SEF_CAUSE_DONE     = 0;  // Calibration finished
  localparam int SEF_CAUSE_ZEROS    = 1;  // Too many zero samples
  localparam int SEF_CAUSE_BASELINE = 2;  // Baseline decreased
  localparam int SEF_CAUSE_OFFSET   = 3;  // Offset register adjusted

  // ----------------------------------------------------------------
  // Slots of the internal sticky flag vector
  // ----------------------------------------------------------------
  localparam int SEF_NFLAGS         = 16;
  localparam int SEF_SLOT_AMB_VALID = 8;
  localparam int SEF_SLOT_PRX_VALID = 9;
  localparam int SEF_SLOT_SYNC_ERR  = 10;
  localparam int SEF_SLOT_FLK_CHG   = 11;
  localparam int SEF_SLOT_CAUSE     = 12;

endpackage

// ### hdl/sef_flag.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// One sticky flag: set wins over clear
// ----------------------------------------------------------------
module sef_flag
(
  input  wire logic clk,      // System clock
  input  wire logic rst,      // Asynchronous reset, high
  input  wire logic set_in,   // Event pulse
  input  wire logic clr_in,   // Clear request
  output logic      flag_q    // Flag, straight from the flop
);

  // Set has priority so an event in the clear cycle survives
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flag_q <= 1'h0;
    end
    else if (set_in)
    begin
      flag_q <= 1'h1;
    end
    else if (clr_in)
    begin
      flag_q <= 1'h0;
    end
  end

endmodule

// ### hdl/sef_status_flags.sv
`timescale 1ns/1ps
module sef_status_flags
  import sef_pkg::*;
(
  input  wire logic                         CLK_SYS,
  input  wire logic                         RESET,
  input  wire logic [7:0]                   REG_ADDR,
  input  wire logic                         REG_WR,
  input  wire logic                         REG_RD,
  input  wire logic [sef_pkg::SEF_DATA_W-1:0] REG_WDATA,
  output logic      [sef_pkg::SEF_DATA_W-1:0] REG_RDATA,
  input  wire logic                         AMBIENT_SATURATION_ENABLE,
  input  wire logic                         FLICKER_SATURATION_ENABLE,
  input  wire logic                         PROXIMITY_SATURATION_ENABLE,
  input  wire logic                         PROXIMITY_EVENT_ENABLE,
  input  wire logic                         AMBIENT_EVENT_ENABLE,
  input  wire logic                         BUFFER_EVENT_ENABLE,
  input  wire logic                         CALIBRATION_EVENT_ENABLE,
  input  wire logic                         SYSTEM_EVENT_ENABLE,
  input  wire logic                         FLICKER_CHANGE_SYSTEM_ENABLE,
  input  wire logic [sef_pkg::SEF_CAUSE_W-1:0] CALIB_FUNC_ENABLE,
  input  wire logic                         AMBIENT_SAT_EVENT,
  input  wire logic                         FLICKER_SAT_EVENT,
  input  wire logic                         PROX_SAT_EVENT,
  input  wire logic                         PROX_THRESHOLD_EVENT,
  input  wire logic                         AMBIENT_THRESHOLD_EVENT,
  input  wire logic [7:0]                   BUFFER_FILL_LEVEL,
  input  wire logic [7:0]                   BUFFER_THRESHOLD,
  input  wire logic                         CALIB_DONE_EVENT,
  input  wire logic                         ZERO_EXCESS_EVENT,
  input  wire logic                         BASELINE_DROP_EVENT,
  input  wire logic                         OFFSET_ADJUST_EVENT,
  input  wire logic [7:0]                   FLICKER_RESULT,
  input  wire logic                         SYNC_ERROR_EVENT,
  input  wire logic                         PROXIMITY_ENGINE_ENABLE,
  input  wire logic                         AMBIENT_ENGINE_ENABLE,
  input  wire logic                         PROX_CYCLE_DONE,
  input  wire logic                         AMBIENT_CYCLE_DONE,
  input  wire logic                         PROXIMITY_RESULT_READ,
  input  wire logic                         AMBIENT_STATUS_READ,
  input  wire logic [sef_pkg::SEF_SAT_DETAIL_W-1:0] PROX_SAT_DETAIL,
  output logic      [sef_pkg::SEF_DATA_W-1:0] PRIMARY_FLAGS,
  output logic      [sef_pkg::SEF_CAUSE_W-1:0] CALIB_CAUSE
);

  import sef_pkg::*;
  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  // Shared by the write clear and the read mux
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [SEF_NFLAGS-1:0]       flag_set;          // Set request per sticky flag
  logic [SEF_NFLAGS-1:0]       flag_clr;          // Clear request per sticky flag
  logic [SEF_NFLAGS-1:0]       flag_q;            // Sticky flag outputs
  logic [SEF_DATA_W-1:0]       prim_clr;          // Write-one clear mask
  logic                        wr_primary;        // Write to primary status
  logic [SEF_CAUSE_W-1:0]      cause_hit;         // Enabled calibration causes
  logic                        buf_cond;          // Buffer level meets threshold
  logic                        buf_set;           // Buffer event this cycle
  logic                        flk_change;        // Flicker result changed
  logic                        sys_detail_evt;    // Any new system detail event
  logic                        prox_en_rise;      // Proximity engine switched on
  logic                        amb_en_rise;       // Ambient engine switched on
  logic [7:0]                  buf_level_reg;     // Last buffer level
  logic                        buf_cond_reg;      // Last buffer condition
  logic [7:0]                  flk_prev_reg;      // Last flicker result
  logic                        flk_primed_reg;    // First flicker sample taken
  logic                        prox_en_reg;       // Last proximity engine enable
  logic                        amb_en_reg;        // Last ambient engine enable
  logic [SEF_SAT_DETAIL_W-1:0] sat_detail_reg;    // Saturation detail
  logic [SEF_DATA_W-1:0]       rdata_next;        // Read mux value
  logic [SEF_DATA_W-1:0]       secondary_view;    // Secondary register image
  logic [SEF_DATA_W-1:0]       sysdetail_view;    // System detail image

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // Only ones in the written byte clear; zeros are ignored
  assign wr_primary = REG_WR & addr_hit(REG_ADDR, SEF_ADDR_PRIMARY);
  assign prim_clr   = wr_primary ? REG_WDATA : SEF_RST_PRIMARY;

  // ----------------------------------------------------------------
  // Event conditioning
  // ----------------------------------------------------------------
  // Buffer condition: nonzero level at or above threshold
  assign buf_cond = (BUFFER_FILL_LEVEL >= BUFFER_THRESHOLD) && (BUFFER_FILL_LEVEL != 8'h00);

  // Retrigger on new data so a clear without draining does not stick
  assign buf_set = buf_cond && (!buf_cond_reg || (BUFFER_FILL_LEVEL > buf_level_reg));

  // Each calibration cause only counts when its function is on
  assign cause_hit = CALIB_FUNC_ENABLE &
                     {OFFSET_ADJUST_EVENT, BASELINE_DROP_EVENT, ZERO_EXCESS_EVENT, CALIB_DONE_EVENT};

  // Ignore the very first sample, it carries no change
  assign flk_change = flk_primed_reg && (FLICKER_RESULT != flk_prev_reg);

  // System summary follows any detail event that is set
  assign sys_detail_evt = (flk_change & FLICKER_CHANGE_SYSTEM_ENABLE) | SYNC_ERROR_EVENT;

  // Engine enable rising edges restart the valid flags
  assign prox_en_rise = PROXIMITY_ENGINE_ENABLE & ~prox_en_reg;
  assign amb_en_rise  = AMBIENT_ENGINE_ENABLE & ~amb_en_reg;

  // ----------------------------------------------------------------
  // History registers
  // ----------------------------------------------------------------
  // Buffer level history for the retrigger
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      buf_level_reg <= 8'h00;
      buf_cond_reg  <= 1'h0;
    end
    else
    begin
      buf_level_reg <= BUFFER_FILL_LEVEL;
      buf_cond_reg  <= buf_cond;
    end
  end

  // Flicker result history for change detection
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      flk_prev_reg   <= 8'h00;
      flk_primed_reg <= 1'h0;
    end
    else
    begin
      flk_prev_reg   <= FLICKER_RESULT;
      flk_primed_reg <= 1'h1;
    end
  end

  // Engine enable history for edge detection
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      prox_en_reg <= 1'h0;
      amb_en_reg  <= 1'h0;
    end
    else
    begin
      prox_en_reg <= PROXIMITY_ENGINE_ENABLE;
      amb_en_reg  <= AMBIENT_ENGINE_ENABLE;
    end
  end

  // Per-channel saturation detail tracks the proximity front end
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      sat_detail_reg <= SEF_RST_SECONDARY[SEF_SAT_DETAIL_W-1:0];
    end
    else
    begin
      sat_detail_reg <= PROX_SAT_DETAIL;
    end
  end

  // ----------------------------------------------------------------
  // Set and clear requests
  // ----------------------------------------------------------------
  // Gated by each enable so disabled sources never raise a primary flag
  always_comb
  begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[SEF_BIT_AMB_SAT]  = AMBIENT_SAT_EVENT & AMBIENT_SATURATION_ENABLE;
    flag_set[SEF_BIT_FLK_SAT]  = FLICKER_SAT_EVENT & FLICKER_SATURATION_ENABLE;
    flag_set[SEF_BIT_PROX_SAT] = PROX_SAT_EVENT & PROXIMITY_SATURATION_ENABLE;
    flag_set[SEF_BIT_PROX_EVT] = PROX_THRESHOLD_EVENT & PROXIMITY_EVENT_ENABLE;
    flag_set[SEF_BIT_AMB_EVT]  = AMBIENT_THRESHOLD_EVENT & AMBIENT_EVENT_ENABLE;
    flag_set[SEF_BIT_BUF_EVT]  = buf_set & BUFFER_EVENT_ENABLE;
    flag_set[SEF_BIT_CAL_EVT]  = (|cause_hit) & CALIBRATION_EVENT_ENABLE;
    flag_set[SEF_BIT_SYS_EVT]  = sys_detail_evt & SYSTEM_EVENT_ENABLE;
    flag_clr[SEF_DATA_W-1:0]   = prim_clr;
    // Valid flags: cycle done sets, restart or readout clears
    flag_set[SEF_SLOT_PRX_VALID] = PROX_CYCLE_DONE;
    flag_clr[SEF_SLOT_PRX_VALID] = prox_en_rise | PROXIMITY_RESULT_READ;
    flag_set[SEF_SLOT_AMB_VALID] = AMBIENT_CYCLE_DONE;
    flag_clr[SEF_SLOT_AMB_VALID] = amb_en_rise | AMBIENT_STATUS_READ;
    // Detail and cause bits go with their summary bit
    flag_set[SEF_SLOT_FLK_CHG]  = flk_change & FLICKER_CHANGE_SYSTEM_ENABLE;
    flag_clr[SEF_SLOT_FLK_CHG]  = prim_clr[SEF_BIT_SYS_EVT];
    flag_set[SEF_SLOT_SYNC_ERR] = SYNC_ERROR_EVENT;
    flag_clr[SEF_SLOT_SYNC_ERR] = prim_clr[SEF_BIT_SYS_EVT];
    flag_set[SEF_SLOT_CAUSE +: SEF_CAUSE_W] = cause_hit;
    flag_clr[SEF_SLOT_CAUSE +: SEF_CAUSE_W] = {SEF_CAUSE_W{prim_clr[SEF_BIT_CAL_EVT]}};
  end

  // ----------------------------------------------------------------
  // Sticky flags
  // ----------------------------------------------------------------
  // One cell per flag; set beats clear inside each cell
  genvar gi;
  generate
    for (gi = 0; gi < SEF_NFLAGS; gi++)
    begin : g_flag
      sef_flag u_flag
      (
        .clk    (CLK_SYS),
        .rst    (RESET),
        .set_in (flag_set[gi]),
        .clr_in (flag_clr[gi]),
        .flag_q (flag_q[gi])
      );
    end
  endgenerate

  // Flags leave straight from their flops
  assign PRIMARY_FLAGS = flag_q[SEF_DATA_W-1:0];
  assign CALIB_CAUSE   = flag_q[SEF_SLOT_CAUSE +: SEF_CAUSE_W];

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Register images; reserved bits read zero
  always_comb
  begin
    secondary_view = SEF_RST_SECONDARY;
    secondary_view[SEF_BIT_PROX_VALID] = flag_q[SEF_SLOT_PRX_VALID];
    secondary_view[SEF_BIT_AMB_VALID]  = flag_q[SEF_SLOT_AMB_VALID];
    secondary_view[SEF_SAT_DETAIL_W-1:0] = sat_detail_reg;
    sysdetail_view = SEF_RST_SYSDETAIL;
    sysdetail_view[SEF_BIT_FLK_CHANGE] = flag_q[SEF_SLOT_FLK_CHG];
    sysdetail_view[SEF_BIT_SYNC_ERR]   = flag_q[SEF_SLOT_SYNC_ERR];
  end

  // Unmapped addresses answer zero
  always_comb
  begin
    rdata_next = SEF_RST_RDATA;
    if (addr_hit(REG_ADDR, SEF_ADDR_PRIMARY))
    begin
      rdata_next = flag_q[SEF_DATA_W-1:0];
    end
    else if (addr_hit(REG_ADDR, SEF_ADDR_SECONDARY))
    begin
      rdata_next = secondary_view;
    end
    else if (addr_hit(REG_ADDR, SEF_ADDR_SYSDETAIL))
    begin
      rdata_next = sysdetail_view;
    end
  end

  // Read data captured one cycle after the strobe, held until the next
  always_ff @(posedge CLK_SYS or posedge RESET)
  begin
    if (RESET)
    begin
      REG_RDATA <= SEF_RST_RDATA;
    end
    else if (REG_RD)
    begin
      REG_RDATA <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  w1c_clears_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    wr_primary |=> ((PRIMARY_FLAGS & $past(REG_WDATA) & ~$past(flag_set[SEF_DATA_W-1:0])) == 8'h00))
    else $error("Primary flag not cleared by write one");
  zero_keeps_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    wr_primary |=> ((~$past(REG_WDATA) & $past(PRIMARY_FLAGS) & ~PRIMARY_FLAGS) == 8'h00))
    else $error("Primary flag lost on zero write");
  set_wins_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (flag_set[SEF_DATA_W-1:0] != 8'h00) |=>
      ((PRIMARY_FLAGS & $past(flag_set[SEF_DATA_W-1:0])) == $past(flag_set[SEF_DATA_W-1:0])))
    else $error("Event lost against clear");
  amb_sat_gate_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(PRIMARY_FLAGS[SEF_BIT_AMB_SAT]) |-> $past(AMBIENT_SAT_EVENT && AMBIENT_SATURATION_ENABLE))
    else $error("Ambient saturation flag rose without enabled event");
  prox_evt_set_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (PROX_THRESHOLD_EVENT && PROXIMITY_EVENT_ENABLE) |=> PRIMARY_FLAGS[SEF_BIT_PROX_EVT])
    else $error("Proximity event flag not set");
  buf_reassert_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_primary && REG_WDATA[SEF_BIT_BUF_EVT] && !buf_set) ##1
      (buf_cond && BUFFER_FILL_LEVEL > buf_level_reg && BUFFER_EVENT_ENABLE) |=> PRIMARY_FLAGS[SEF_BIT_BUF_EVT])
    else $error("Buffer flag did not reassert on new data");
  cal_cause_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ((cause_hit != 4'h0) && CALIBRATION_EVENT_ENABLE) |=>
      (PRIMARY_FLAGS[SEF_BIT_CAL_EVT] && ((CALIB_CAUSE & $past(cause_hit)) == $past(cause_hit))))
    else $error("Calibration flag or cause missing");
  sys_summary_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(PRIMARY_FLAGS[SEF_BIT_SYS_EVT]) |-> $past(sys_detail_evt && SYSTEM_EVENT_ENABLE))
    else $error("System flag rose without detail event");
  flk_detail_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (flk_primed_reg && FLICKER_RESULT != flk_prev_reg && FLICKER_CHANGE_SYSTEM_ENABLE) |=>
      flag_q[SEF_SLOT_FLK_CHG])
    else $error("Flicker change detail not set");
  prox_valid_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (PROXIMITY_RESULT_READ && !PROX_CYCLE_DONE) ##1 (!PROX_CYCLE_DONE) |=> !flag_q[SEF_SLOT_PRX_VALID])
    else $error("Proximity valid not cleared by readout");
  amb_valid_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    AMBIENT_CYCLE_DONE |=> flag_q[SEF_SLOT_AMB_VALID])
    else $error("Ambient valid not set after cycle");
  sat_detail_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    ##1 (sat_detail_reg == $past(PROX_SAT_DETAIL)))
    else $error("Saturation detail does not follow front end");
  read_data_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (REG_RD && addr_hit(REG_ADDR, SEF_ADDR_PRIMARY)) |=> (REG_RDATA == $past(PRIMARY_FLAGS)))
    else $error("Primary read data wrong");

endmodule

// ### sim/sef_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host model: master of the serial register port
// ----------------------------------------------------------------
module sef_host
(
  input  wire logic       clk,             // System clock
  output logic      [7:0] addr  = 8'h00,   // Register address
  output logic            wr    = 1'b0,    // Write strobe
  output logic            rd    = 1'b0,    // Read strobe
  output logic      [7:0] wdata = 8'h00,   // Write data
  input  wire logic [7:0] rdata            // Read data
);
  // One write; released lines flip so stale values never pass
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
    #1;
  endtask
  // One read; data taken once the registered answer lands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
  // Read, service, write the same value back
  task automatic service(output logic [7:0] d);
    rd_reg(8'hb7, d);
    wr_reg(8'hb7, d);
  endtask
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench of the event status flags
// ----------------------------------------------------------------
module tb;
  import sef_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, proximity_engine_enable = 1'b0, ambient_engine_enable = 1'b0, fce = 1'b0, wr, rd;
  logic [7:0]  en = 8'h00, lvl = 8'h00, thr = 8'h00, flk = 8'h00, addr, wdata, rdata, pf, v;
  logic [13:0] ev = 14'h0000;  // Event pulses, one slot each
  logic [3:0]  cfe = 4'h0, cause;
  logic [5:0]  det = 6'h00;
  int          bad_count = 0, tests_run = 0;

  sef_host u_sef_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata));
  sef_status_flags u_sef_status_flags (.CLK_SYS(clk), .RESET(rst), .REG_ADDR(addr), .REG_WR(wr),
    .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata), .AMBIENT_SATURATION_ENABLE(en[7]),
    .FLICKER_SATURATION_ENABLE(en[6]), .PROXIMITY_SATURATION_ENABLE(en[5]), .PROXIMITY_EVENT_ENABLE(en[4]),
    .AMBIENT_EVENT_ENABLE(en[3]), .BUFFER_EVENT_ENABLE(en[2]), .CALIBRATION_EVENT_ENABLE(en[1]),
    .SYSTEM_EVENT_ENABLE(en[0]), .FLICKER_CHANGE_SYSTEM_ENABLE(fce), .CALIB_FUNC_ENABLE(cfe),
    .AMBIENT_SAT_EVENT(ev[0]), .FLICKER_SAT_EVENT(ev[1]), .PROX_SAT_EVENT(ev[2]),
    .PROX_THRESHOLD_EVENT(ev[3]), .AMBIENT_THRESHOLD_EVENT(ev[4]), .BUFFER_FILL_LEVEL(lvl),
    .BUFFER_THRESHOLD(thr), .CALIB_DONE_EVENT(ev[5]), .ZERO_EXCESS_EVENT(ev[6]), .BASELINE_DROP_EVENT(ev[7]),
    .OFFSET_ADJUST_EVENT(ev[8]), .FLICKER_RESULT(flk), .SYNC_ERROR_EVENT(ev[9]), .PROXIMITY_ENGINE_ENABLE(proximity_engine_enable),
    .AMBIENT_ENGINE_ENABLE(ambient_engine_enable), .PROX_CYCLE_DONE(ev[10]), .AMBIENT_CYCLE_DONE(ev[11]),
    .PROXIMITY_RESULT_READ(ev[12]), .AMBIENT_STATUS_READ(ev[13]), .PROX_SAT_DETAIL(det),
    .PRIMARY_FLAGS(pf), .CALIB_CAUSE(cause));

  // ----------------------------------------------------------------
  // Clock, shared helpers
  // ----------------------------------------------------------------
  initial forever #12.5 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle event pulse, then let the flag land
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    tick(1);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Saturation and threshold bits: gated, then serviced
  task automatic t_gate;
    for (int i = 0; i < 5; i++)
    begin
      pulse(i);
      chk(pf, 8'h00);
      @(posedge clk);
      en[7-i] <= 1'b1;
      pulse(i);
      chk(pf, 8'h80 >> i);
      u_sef_host.service(v);
      chk(pf, 8'h00);
    end
  endtask
  // Zero keeps, one clears, set beats clear, read-only and unmapped places
  task automatic t_clear;
    pulse(0);
    pulse(4);
    u_sef_host.wr_reg(8'hb7, 8'h08);
    chk(pf, 8'h80);
    u_sef_host.wr_reg(8'hb8, 8'hff);
    u_sef_host.wr_reg(8'hb7, 8'h04);
    chk(pf, 8'h80);
    fork
      u_sef_host.wr_reg(8'hb7, 8'h80);
      pulse(0);
    join
    chk(pf, 8'h80);
    u_sef_host.rd_reg(8'h10, v);
    chk(v, 8'h00);
    u_sef_host.wr_reg(8'hb7, 8'hff);
    chk(pf, 8'h00);
  endtask
  // Buffer level flag comes back on new data until the buffer is empty
  task automatic t_buffer;
    @(posedge clk);
    en <= 8'hff;
    thr <= 8'h04;
    lvl <= 8'h04;
    tick(2);
    chk(pf, 8'h04);
    // New data is seen on the edge after the one that takes the clear
    fork
      u_sef_host.wr_reg(8'hb7, 8'h04);
      begin
        repeat (2) @(posedge clk);
        lvl <= 8'h05;
      end
    join
    tick(2);
    chk(pf, 8'h04);
    @(posedge clk);
    lvl <= 8'h00;
    u_sef_host.wr_reg(8'hb7, 8'h04);
    tick(2);
    chk(pf, 8'h00);
  endtask
  // Each calibration cause, only with its function enabled
  task automatic t_calib;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      cfe <= 4'h0;
      pulse(5 + k);
      chk(pf, 8'h00);
      @(posedge clk);
      cfe <= 4'h1 << k;
      pulse(5 + k);
      chk(pf, 8'h02);
      chk(cause, 8'h01 << k);
      u_sef_host.wr_reg(8'hb7, 8'h02);
      chk(cause, 8'h00);
    end
  endtask
  // System summary from flicker change and sync error
  task automatic t_sys;
    @(posedge clk);
    fce <= 1'b1;
    flk <= 8'h5a;
    tick(2);
    u_sef_host.rd_reg(8'hbb, v);
    chk(v, 8'h08);
    chk(pf, 8'h01);
    u_sef_host.wr_reg(8'hb7, 8'h01);
    pulse(9);
    u_sef_host.rd_reg(8'hbb, v);
    chk(v, 8'h01);
    chk(pf, 8'h01);
    u_sef_host.wr_reg(8'hb7, 8'h01);
  endtask
  // Valid flags and per-channel saturation detail
  task automatic t_valid;
    @(posedge clk);
    det <= 6'h2a;
    proximity_engine_enable <= 1'b1;
    ambient_engine_enable <= 1'b1;
    pulse(10);
    pulse(11);
    u_sef_host.rd_reg(8'hb8, v);
    chk(v, 8'hea);
    pulse(12);
    u_sef_host.rd_reg(8'hb8, v);
    chk(v, 8'h6a);
    pulse(13);
    u_sef_host.rd_reg(8'hb8, v);
    chk(v, 8'h2a);
    // Complementary pattern so every detail bit is seen both ways
    @(posedge clk);
    det <= 6'h15;
    tick(2);
    u_sef_host.rd_reg(8'hb8, v);
    chk(v, 8'h15);
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog, verdict
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk(pf, 8'h00);
    u_sef_host.rd_reg(8'hb7, v);
    chk(v, 8'h00);
    u_sef_host.rd_reg(8'hb8, v);
    chk(v, 8'h00);
    t_gate;
    t_clear;
    t_buffer;
    t_calib;
    t_sys;
    t_valid;
    wrap_up;
  end
  // Run needs well under a thousand cycles
  initial
  begin
    #200000;
    bad_count++;
    wrap_up;
  end
endmodule
